// ===== hdl/crms_pkg.sv
// Purpose: Shared constants for the CAN receive message storage block.
// Assumes: APB3 register access, 32-bit data, one word per register.
// Notes:   Buffer geometry and the register map live here only.
package crms_pkg;

  // ----------------------------------------------------------------------
  // Buffer geometry
  // ----------------------------------------------------------------------
  localparam int unsigned MSG_BYTES = 13;   // Control bits, identifier, data
  localparam int unsigned TX_BUFS   = 3;    // Transmit buffers
  localparam int unsigned PORT_W    = 8;    // Width of the CAN port
  localparam int unsigned RX_PIN    = 0;    // Receive pin position
  localparam int unsigned TX_PIN    = 1;    // Transmit pin position

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00; // Mode and interrupt enables
  localparam logic [7:0] OFS_RFLG  = 8'h04; // Receiver flag register
  localparam logic [7:0] OFS_PDAT  = 8'h08; // Port data, bits 7..2
  localparam logic [7:0] OFS_PDIR  = 8'h0C; // Port direction, bits 7..2
  localparam logic [7:0] OFS_TFLG  = 8'h10; // Transmit buffer empty flags
  localparam logic [7:0] OFS_TPRIO = 8'h14; // Local priorities, 8 bits each
  localparam logic [1:0] SEL_FGND  = 2'h1;  // addr[7:6]: foreground buffer window
  localparam logic [1:0] SEL_TXB0  = 2'h2;  // addr[7:6]: transmit buffers 0..1
  localparam logic [1:0] SEL_TXB1  = 2'h3;  // addr[7:6]: transmit buffer 2

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_LOOP  = 0;   // Loop-back mode
  localparam int unsigned CTRL_RXIE  = 1;   // Receive interrupt enable
  localparam int unsigned CTRL_OVRIE = 2;   // Overrun error interrupt enable
  localparam int unsigned RFLG_FULL  = 0;   // Receive-full flag
  localparam int unsigned RFLG_OVR   = 1;   // Overrun flag

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] RST_CTRL = 3'h0;
  localparam logic [2:0] RST_TXE  = 3'h7;   // All transmit buffers empty
  localparam logic [7:0] RST_PRIO = 8'h00;

endpackage : crms_pkg

// ===== hdl/crms_sync.sv
// Purpose: Two-flop synchroniser for a bus of pin inputs.
// Assumes: Each bit is an independent level; no bus coherence implied.
// Notes:   The first stage feeds only the second stage.
module crms_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ----------------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta;   // First stage, read by second stage only
    logic [W-1:0] held;   // Second stage, the only one logic may read
  } crms_sync_s;

  crms_sync_s sy_reg;    // Registered stages
  crms_sync_s sy_next;   // Next stages

  // Each stage takes the one before it
  always_comb begin
    sy_next      = sy_reg;
    sy_next.meta = d;
    sy_next.held = sy_reg.meta;
  end

  // Pins idle recessive, so both stages reset high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy_reg <= '1;
    end else begin
      sy_reg <= sy_next;
    end
  end

  assign q = sy_reg.held;

endmodule : crms_sync

// ===== hdl/crms_prio.sv
// Purpose: Picks the ready transmit buffer with the highest local priority.
// Assumes: Lowest binary priority value wins; ties go to the lowest index.
// Notes:   Pure combinational; the caller registers the result.
module crms_prio
  import crms_pkg::*;
#(
  parameter int unsigned N = TX_BUFS
) (
  input  wire logic [N-1:0]      ready,
  input  wire logic [N-1:0][7:0] prio,
  output logic                   any,
  output logic      [1:0]        idx
);

  // ----------------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------------
  logic [7:0] best;   // Priority of the current winner

  // Strict compare keeps the lower index on a tie
  always_comb begin
    any  = 1'b0;
    idx  = 2'h0;
    best = 8'hFF;
    for (int i = 0; i < N; i++) begin
      if (ready[i] && (!any || prio[i] < best)) begin
        any  = 1'b1;
        idx  = 2'(i);
        best = prio[i];
      end
    end
  end

endmodule : crms_prio

// ===== hdl/crms_top.sv
// Purpose: Receive message storage, transmit queue and CAN port pins.
// Assumes: A bit-level protocol engine on pclk delivers bytes and frame
//          events, and reports filter hits, arbitration loss and sends.
// Notes:   Registers over APB3; answer comes two cycles after setup.
//
// Design decisions made here: the APB interface to the registers and the address map.
module crms_top
  import crms_pkg::*;
#(
  parameter int unsigned NBYTES = MSG_BYTES,
  parameter int unsigned NTX    = TX_BUFS
) (
  input  wire logic              pclk,            // 200 MHz module clock
  input  wire logic              presetn,         // Asynchronous, active low
  input  wire logic [7:0]        paddr,           // APB byte address
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [PORT_W-1:0] can_port_in,     // Pin levels
  output logic      [PORT_W-1:0] can_port_out,    // Pin drive values
  output logic      [PORT_W-1:0] can_port_oe_n,   // Low while driving
  output logic                   rx_irq,          // Receive interrupt
  output logic                   err_irq,         // Overrun error interrupt
  output logic                   eng_rx_bit,      // Synchronised receive pin
  input  wire logic              eng_tx_bit,      // Bus level to send
  input  wire logic              eng_rx_start,    // Pulse: start of frame
  input  wire logic              eng_rx_byte_vld, // Pulse: byte received
  input  wire logic [7:0]        eng_rx_byte,
  input  wire logic              eng_rx_ok,       // Pulse: frame ended well
  input  wire logic              eng_accept,      // Filter hit, valid at ok
  input  wire logic              eng_tx_active,   // Level: node transmitting
  input  wire logic              eng_arb_lost,    // Pulse: arbitration lost
  input  wire logic              eng_tx_done,     // Pulse: frame sent
  input  wire logic [3:0]        eng_tx_byte_idx, // Byte of frame wanted
  output logic                   eng_ack_en,      // Engine may acknowledge
  output logic                   eng_tx_req,      // A frame is queued
  output logic      [1:0]        eng_tx_idx,      // Buffer being offered
  output logic      [7:0]        eng_tx_data      // Byte, one cycle late
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef logic [NBYTES-1:0][7:0] crms_msg_t;

  typedef struct packed {
    logic                   loopback;  // Own frames treated as foreign
    logic                   rx_ie;     // Receive interrupt enable
    logic                   ovr_ie;    // Overrun interrupt enable
    logic                   rx_full;   // Receive-full flag
    logic                   ovr;       // Overrun flag
    logic                   bg_pend;   // Background holds accepted frame
    logic                   own;       // Current frame is our own
    logic                   lost;      // Current frame lost bytes to a held buffer
    logic [3:0]             wptr;      // Background write index
    crms_msg_t              bg;        // Background receive buffer
    crms_msg_t              fg;        // Foreground receive buffer
    logic [NTX-1:0]         txe;       // Transmit buffer empty flags
    logic [NTX-1:0][7:0]    prio;      // Local priorities
    crms_msg_t [NTX-1:0]    txb;       // Transmit buffers
    logic                   tx_req;
    logic [1:0]             tx_idx;
    logic [7:0]             tx_data;
    logic [PORT_W-1:2]      pdat;      // General-purpose port data
    logic [PORT_W-1:2]      pdir;      // 1 = output
    logic [PORT_W-1:0]      pout;
    logic [PORT_W-1:0]      poe_n;
    logic                   rx_irq;
    logic                   err_irq;
    logic                   ack_en;
    logic                   rx_bit;    // Receive pin, third flop
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
  } crms_state_s;

  crms_state_s st_reg;    // Registered state
  crms_state_s st_next;   // Next state

  logic [PORT_W-1:0] pin_sync;   // Synchronised port pins
  logic              sel_any;    // Some buffer is ready
  logic [1:0]        sel_idx;    // Winning buffer

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  // Pins come from outside the clock domain
  crms_sync #(.W(PORT_W)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (can_port_in),
    .q       (pin_sync)
  );

  // Ready means scheduled, that is, empty flag cleared
  crms_prio #(.N(NTX)) u_prio (
    .ready (~st_reg.txe),
    .prio  (st_reg.prio),
    .any   (sel_any),
    .idx   (sel_idx)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Packs up to four bytes of a message into a word; bytes past the end read 0
  function automatic logic [31:0] msg_word(input crms_msg_t m, input logic [1:0] w);
    logic [31:0] r;
    int unsigned k;
    r = 32'h0000_0000;
    for (int j = 0; j < 4; j++) begin
      k = 4 * int'(w) + j;
      if (k < NBYTES) begin
        r[8*j +: 8] = m[k];
      end
    end
    return r;
  endfunction : msg_word

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  logic        own_eff;    // Own frame outside loop-back
  logic        wr_en;      // APB write commits this edge
  logic        rd_go;      // APB access being answered
  logic [1:0]  word;       // Word within a message window
  logic [1:0]  tbuf;       // Transmit buffer addressed
  logic        hit;        // Address decodes
  logic [31:0] rdat;       // Read data

  always_comb begin
    st_next = st_reg;
    own_eff = st_reg.own && !st_reg.loopback;
    wr_en   = psel && penable && pwrite && st_reg.pready;
    rd_go   = psel && penable && !st_reg.pready;
    word    = paddr[3:2];
    hit     = 1'b0;
    rdat    = 32'h0000_0000;

    // Transmit buffer index from window: 0x80,0x90 -> 0,1; 0xC0 -> 2
    tbuf = (paddr[7:6] == SEL_TXB0) ? {1'b0, paddr[4]} : 2'h2;

    // Address decode and read mux
    if (paddr[5:4] == 2'h0 && paddr[7:6] == SEL_FGND) begin
      hit  = 1'b1;
      rdat = msg_word(st_reg.fg, word);
    end else if ((paddr[7:6] == SEL_TXB0 && !paddr[5]) ||
                 (paddr[7:6] == SEL_TXB1 && paddr[5:4] == 2'h0)) begin
      hit  = 1'b1;
      rdat = msg_word(st_reg.txb[tbuf], word);
    end else begin
      case (paddr)
        OFS_CTRL: begin
          hit  = 1'b1;
          rdat = {29'h0, st_reg.ovr_ie, st_reg.rx_ie, st_reg.loopback};
        end
        OFS_RFLG: begin
          hit  = 1'b1;
          rdat = {30'h0, st_reg.ovr, st_reg.rx_full};
        end
        OFS_PDAT: begin
          hit = 1'b1;
          // Inputs read the pin, outputs read the latch
          rdat[7:2] = (pin_sync[7:2] & ~st_reg.pdir) | (st_reg.pdat & st_reg.pdir);
          rdat[1:0] = pin_sync[1:0];
        end
        OFS_PDIR: begin
          hit       = 1'b1;
          rdat[7:2] = st_reg.pdir;
        end
        OFS_TFLG: begin
          hit       = 1'b1;
          rdat[2:0] = st_reg.txe;
        end
        OFS_TPRIO: begin
          hit        = 1'b1;
          rdat[23:0] = st_reg.prio;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end

    // APB answer: ready one cycle into the access phase
    st_next.pready  = rd_go;
    st_next.pslverr = rd_go && !hit;
    st_next.prdata  = rd_go ? rdat : 32'h0000_0000;

    // Register writes
    if (wr_en && hit) begin
      case (paddr)
        OFS_CTRL: begin
          st_next.loopback = pwdata[CTRL_LOOP];
          st_next.rx_ie    = pwdata[CTRL_RXIE];
          st_next.ovr_ie   = pwdata[CTRL_OVRIE];
        end
        OFS_RFLG: begin
          // Write one clears; later sets in this cycle override
          if (pwdata[RFLG_FULL]) st_next.rx_full = 1'b0;
          if (pwdata[RFLG_OVR]) st_next.ovr = 1'b0;
        end
        OFS_PDAT:  st_next.pdat = pwdata[7:2];
        OFS_PDIR:  st_next.pdir = pwdata[7:2];
        OFS_TFLG: begin
          // Writing one schedules the buffer for sending
          st_next.txe = st_reg.txe & ~pwdata[NTX-1:0];
        end
        OFS_TPRIO: st_next.prio = pwdata[23:0];
        default: begin
          // Buffer windows: only transmit buffers are writable
          if (paddr[7:6] != SEL_FGND && st_reg.txe[tbuf]) begin
            for (int j = 0; j < 4; j++) begin
              if (4 * int'(word) + j < NBYTES) begin
                st_next.txb[tbuf][4 * int'(word) + j] = pwdata[8*j +: 8];
              end
            end
          end
        end
      endcase
    end

    // Frame start: fresh write pointer, remember whether we sent it
    if (eng_rx_start) begin
      st_next.wptr = 4'h0;
      st_next.lost = 1'b0;
      st_next.own  = eng_tx_active;
    end

    // Losing arbitration makes the frame a foreign one
    if (eng_arb_lost) begin
      st_next.own = 1'b0;
    end

    // Bytes land in background unless it holds a pending accepted frame;
    // the index still advances so that later bytes never shift position
    if (eng_rx_byte_vld && st_reg.wptr < NBYTES[3:0]) begin
      if (st_reg.bg_pend) begin
        st_next.lost = 1'b1;
      end else begin
        st_next.bg[st_reg.wptr] = eng_rx_byte;
      end
      st_next.wptr = st_reg.wptr + 4'h1;
    end

    // Frame complete: promote, park or discard; a frame that lost bytes
    // to a held background is the newest one and is never promoted
    if (eng_rx_ok && eng_accept && !own_eff) begin
      if (st_reg.bg_pend || st_reg.lost) begin
        st_next.ovr = 1'b1;
      end else if (!st_reg.rx_full) begin
        st_next.fg      = st_reg.bg;
        st_next.rx_full = 1'b1;
      end else begin
        st_next.bg_pend = 1'b1;
      end
    end

    // Queued frame moves forward once software frees the foreground
    if (st_reg.bg_pend && !st_reg.rx_full) begin
      st_next.fg      = st_reg.bg;
      st_next.rx_full = 1'b1;
      st_next.bg_pend = 1'b0;
    end

    // Transmit queue keeps running regardless of receive state
    if (eng_tx_done) begin
      st_next.txe[st_reg.tx_idx] = 1'b1;
    end
    st_next.tx_req = sel_any && !(eng_tx_done && sel_idx == st_reg.tx_idx);
    if (!eng_tx_active) begin
      st_next.tx_idx = sel_idx;
    end
    st_next.tx_data = (eng_tx_byte_idx < NBYTES[3:0]) ?
                      st_reg.txb[st_reg.tx_idx][eng_tx_byte_idx] : 8'h00;

    // Acknowledge suppressed for own frames unless looped back
    st_next.ack_en = !(eng_tx_active && !st_reg.loopback);

    // Interrupt levels follow flags and masks
    st_next.rx_irq  = st_next.rx_full && st_next.rx_ie;
    st_next.err_irq = st_next.ovr && st_next.ovr_ie;

    // Port pins: receive in, transmit out, the rest general purpose
    st_next.pout               = {st_reg.pdat, 2'b11};
    st_next.pout[TX_PIN]       = eng_tx_bit;
    st_next.poe_n              = {~st_reg.pdir, 2'b11};
    st_next.poe_n[TX_PIN]      = 1'b0;
    st_next.poe_n[RX_PIN]      = 1'b1;
    // The receive pin reaches the engine only through the synchroniser
    st_next.rx_bit             = pin_sync[RX_PIN];
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Everything resets to a constant; transmit pin idles recessive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg          <= '0;
      st_reg.loopback <= RST_CTRL[CTRL_LOOP];
      st_reg.txe      <= RST_TXE;
      st_reg.prio     <= {NTX{RST_PRIO}};
      st_reg.pout     <= '1;
      st_reg.poe_n    <= '1;
      st_reg.ack_en   <= 1'b1;
      st_reg.rx_bit   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Every output is a field of the state register
  assign eng_rx_bit    = st_reg.rx_bit;
  assign prdata        = st_reg.prdata;
  assign pready        = st_reg.pready;
  assign pslverr       = st_reg.pslverr;
  assign can_port_out  = st_reg.pout;
  assign can_port_oe_n = st_reg.poe_n;
  assign rx_irq        = st_reg.rx_irq;
  assign err_irq       = st_reg.err_irq;
  assign eng_ack_en    = st_reg.ack_en;
  assign eng_tx_req    = st_reg.tx_req;
  assign eng_tx_idx    = st_reg.tx_idx;
  assign eng_tx_data   = st_reg.tx_data;

endmodule : crms_top

// ===== verif/crms_xcvr_model.sv
// Purpose: Transceiver and bus model on the far side of the CAN pins.
// Assumes: Wired-AND bus; a low level is dominant.
// Notes:   Another node may pull the bus dominant through other_dom_n.
module crms_xcvr_model (
  input  wire logic can_transmit_pin, // Node drive level
  input  wire logic other_dom_n,      // Low: a second node is dominant
  output logic      can_receive_pin   // Bus level seen by the node
);
  timeunit 1ns;
  timeprecision 1ps;
  // Dominant from either side wins; the echo is how own frames come back
  assign can_receive_pin = can_transmit_pin & other_dom_n;
endmodule : crms_xcvr_model

// ===== verif/crms_top_sva.sv
// Purpose: Port-level checks for crms_top.
// Assumes: One clock; presetn asynchronous, active low.
// Notes:   Interrupt edges are tied to their causes, not to hidden flags.
module crms_top_sva #(
  parameter int unsigned NBYTES = 13
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       pready,
  input wire logic [7:0] can_port_in,
  input wire logic [7:0] can_port_out,
  input wire logic [7:0] can_port_oe_n,
  input wire logic       rx_irq,
  input wire logic       err_irq,
  input wire logic       eng_rx_bit,
  input wire logic       eng_tx_bit,
  input wire logic       eng_rx_ok,
  input wire logic       eng_tx_active,
  input wire logic       eng_ack_en,
  input wire logic [3:0] eng_tx_byte_idx,
  input wire logic [7:0] eng_tx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_tx_pin_level: assert property (can_port_out[1] == $past(eng_tx_bit))
    else $error("transmit pin does not follow the bus level");
  chk_rx_bit_sync: assert property (eng_rx_bit == $past(can_port_in[0], 3))
    else $error("receive pin not seen three cycles later");
  chk_pin_roles: assert property ($past(presetn) |-> !can_port_oe_n[1] && can_port_oe_n[0])
    else $error("receive or transmit pin has the wrong direction");
  chk_rx_irq_cause: assert property ($rose(rx_irq) |->
    $past(eng_rx_ok) || $past(pready) || $past(pready, 2))
    else $error("receive interrupt rose without a frame or a write");
  chk_rx_irq_hold: assert property ($fell(rx_irq) |-> $past(pready))
    else $error("receive interrupt dropped without a write");
  chk_err_irq_cause: assert property ($rose(err_irq) |->
    $past(eng_rx_ok) || $past(pready) || $past(pready, 2))
    else $error("error interrupt rose without a frame or a write");
  chk_ack_own_off: assert property (!eng_ack_en |-> $past(eng_tx_active))
    else $error("acknowledge withheld while not transmitting");
  chk_tx_byte_end: assert property ($past(eng_tx_byte_idx) >= NBYTES |-> eng_tx_data == 8'h00)
    else $error("byte past the buffer end is not zero");
endmodule : crms_top_sva
bind crms_top crms_top_sva #(.NBYTES(NBYTES)) crms_top_sva_i (.pclk, .presetn, .pready,
  .can_port_in, .can_port_out, .can_port_oe_n, .rx_irq, .err_irq, .eng_rx_bit, .eng_tx_bit,
  .eng_rx_ok, .eng_tx_active, .eng_ack_en, .eng_tx_byte_idx, .eng_tx_data);

// ===== verif/can_receive_message_storage_tb.sv
// Purpose: Self-checking bench for crms_top over APB, engine side and pins.
// Assumes: Every input changes by non-blocking assignment as pclk rises.
// Notes:   Frame byte n is base+n, so buffer contents are predictable.
module can_receive_message_storage_tb
  import crms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tx_bit = 1'b1;
  logic        rx_start = 1'b0, rx_vld = 1'b0, rx_ok = 1'b0, accept = 1'b0, tx_done = 1'b0;
  logic        tx_act = 1'b0, arb_lost = 1'b0, other_n = 1'b1;
  logic [7:0]  paddr = 8'h00, rx_byte = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [5:0]  gpio = 6'h15;
  logic [3:0]  tx_bidx = 4'h0;
  logic        pclk, pready, pslverr, err, rx_irq, err_irq, rx_bit, ack_en, tx_req, rx_pin;
  logic [7:0]  pout, poe_n, tx_data;
  logic [31:0] prdata, rd;
  logic [1:0]  tx_idx;
  int          fail_count, checked;
  wire [7:0]   port_in = {gpio, 1'b1, rx_pin}; // Bit 1 is output only
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  crms_top crms_top_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .can_port_in(port_in), .can_port_out(pout), .can_port_oe_n(poe_n), .rx_irq(rx_irq),
    .err_irq(err_irq), .eng_rx_bit(rx_bit), .eng_tx_bit(tx_bit), .eng_rx_start(rx_start),
    .eng_rx_byte_vld(rx_vld), .eng_rx_byte(rx_byte), .eng_rx_ok(rx_ok), .eng_accept(accept),
    .eng_tx_active(tx_act), .eng_arb_lost(arb_lost), .eng_tx_done(tx_done),
    .eng_tx_byte_idx(tx_bidx), .eng_ack_en(ack_en), .eng_tx_req(tx_req),
    .eng_tx_idx(tx_idx), .eng_tx_data(tx_data));
  crms_xcvr_model crms_xcvr_model_i (
    .can_transmit_pin(pout[1]), .other_dom_n(other_n), .can_receive_pin(rx_pin));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; a missing answer ends the run after 20 cycles
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rc
  // Start, 14 bytes (the last one lies past the buffer), then end of frame;
  // lose pulses an arbitration loss together with the first byte
  task automatic frame(input logic [7:0] base, input logic acc, input logic lose = 1'b0);
    rx_start <= 1'b1;
    @(posedge pclk);
    rx_start <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      rx_vld <= 1'b1;
      rx_byte <= base + 8'(i);
      arb_lost <= lose && (i == 0);
      @(posedge pclk);
    end
    rx_vld <= 1'b0;
    arb_lost <= 1'b0;
    rx_ok <= 1'b1;
    accept <= acc;
    @(posedge pclk);
    rx_ok <= 1'b0;
    @(posedge pclk);
  endtask : frame
  task automatic chk_fg(input logic [7:0] base);
    logic [31:0] e;
    for (int w = 0; w < 4; w++) begin
      for (int b = 0; b < 4; b++) begin
        e[8*b +: 8] = (4*w + b < MSG_BYTES) ? base + 8'(4*w + b) : 8'h00;
      end
      rc(8'h40 + 8'(4*w), e);
    end
  endtask : chk_fg
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(OFS_CTRL, 32'h0);
    rc(OFS_RFLG, 32'h0);
    rc(OFS_TFLG, 32'h7);
    apb(1'b0, 8'h18, 32'h0);
    check(32'(err), 32'h1);
    apb(1'b1, OFS_CTRL, 32'h6);
    frame(8'h10, 1'b1);
    rc(OFS_RFLG, 32'h1);
    check(32'(rx_irq), 32'h1);
    chk_fg(8'h10);
    frame(8'h30, 1'b1);
    chk_fg(8'h10);
    frame(8'h50, 1'b1);
    rc(OFS_RFLG, 32'h3);
    check(32'(err_irq), 32'h1);
    // Transmit queue while both receive buffers are full
    apb(1'b1, 8'h80, 32'hA1B2C3D4);
    apb(1'b1, 8'hC4, 32'h11223344);
    rc(8'hC4, 32'h11223344);
    apb(1'b1, OFS_TPRIO, 32'h00051020);
    apb(1'b1, OFS_TFLG, 32'h7);
    rc(OFS_TFLG, 32'h0);
    check(32'(tx_req), 32'h1);
    for (int k = 0; k < 3; k++) begin
      check(32'(tx_idx), 32'(2 - k));
      check(32'(tx_req), 32'h1);
      if (k == 2) begin
        check(32'(tx_data), 32'hD4);
      end
      tx_done <= 1'b1;
      @(posedge pclk);
      tx_done <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    rc(OFS_TFLG, 32'h7);
    check(32'(tx_req), 32'h0);
    apb(1'b1, OFS_RFLG, 32'h1);
    rc(OFS_RFLG, 32'h3);
    chk_fg(8'h30);
    apb(1'b1, OFS_RFLG, 32'h3);
    rc(OFS_RFLG, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0);
    frame(8'h70, 1'b0);
    rc(OFS_RFLG, 32'h0);
    tx_act <= 1'b1;
    frame(8'h70, 1'b1);
    check(32'(ack_en), 32'h0);
    rc(OFS_RFLG, 32'h0);
    frame(8'hB0, 1'b1, 1'b1);
    rc(OFS_RFLG, 32'h1);
    apb(1'b1, OFS_RFLG, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h1);
    frame(8'h90, 1'b1);
    check(32'(ack_en), 32'h1);
    tx_act <= 1'b0;
    rc(OFS_RFLG, 32'h1);
    check(32'(rx_irq), 32'h0);
    chk_fg(8'h90);
    apb(1'b1, OFS_PDIR, 32'hF0);
    apb(1'b1, OFS_PDAT, 32'hA8);
    apb(1'b0, OFS_PDAT, 32'h0);
    check(32'(rd[7:2]), 32'h29);
    check(32'(poe_n[7:2]), 32'h03);
    check(32'(pout[7:2]), 32'h2A);
    tx_bit <= 1'b0;
    tx_bidx <= 4'hD;
    repeat (5) @(posedge pclk);
    check(32'(pout[1]), 32'h0);
    check(32'(rx_bit), 32'h0);
    check(32'(tx_data), 32'h0);
    give_verdict();
  end
endmodule : can_receive_message_storage_tb
